// [ttc_timer.sv]
// three channel timer counter with classic wishbone register access
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ttc_cfg.svh"
module ttc_timer
	import ttc_pkg::*;
#(
	parameter int NCH = 3,
	parameter int CW = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// external clock pins, one per channel
	input wire logic [2:0] extClkPin,
	// multipurpose lines
	input wire logic [2:0] lineAIn,
	output logic [2:0] lineAOut,
	output logic [2:0] lineAOe,
	input wire logic [2:0] lineBIn,
	output logic [2:0] lineBOut,
	output logic [2:0] lineBOe,
	// per channel interrupt lines
	output logic [2:0] irq
);

	logic rstMeta_r;
	logic rstSync_r;
	logic [`TTC_PRESC_W-1:0] presc_r;
	logic [5:0] blockMode_r;
	logic syncTrg;
	logic busReq;
	logic wrStb;
	logic rdStb;
	logic [31:0] rdMux;
	logic [CW-1:0] cnt_r [NCH];
	logic [CW-1:0] capA_r [NCH];
	logic [CW-1:0] capB_r [NCH];
	logic [CW-1:0] cmpC_r [NCH];
	logic [15:0] mode_r [NCH];
	ttc_flags_t flags_r [NCH];
	ttc_flags_t mask_r [NCH];
	logic [NCH-1:0] clkEn_r;
	logic [NCH-1:0] lineAOut_r;
	logic [NCH-1:0] lineBOut_r;

	// word hit on a channel register
	function automatic logic chHit(input logic [7:0] adr, input int ch, input logic [5:0] off);
		chHit = (adr[7:6] == 2'(ch)) && (adr[5:0] == off);
	endfunction : chHit

	// write data masked by byte enables, low half only matters for most registers
	function automatic logic [31:0] selData(input logic [31:0] d, input logic [3:0] s);
		selData = d & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction : selData

	// reset released through two flops, asserted at once
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_r <= 1'b0;
			rstSync_r <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstSync_r <= rstMeta_r;
		end
	end

	// bus: ack one cycle after request, then drops for a cycle
	assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wrStb = busReq && wb_we_i;
	assign rdStb = busReq && !wb_we_i;

	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= busReq;
			wb_dat_o <= rdStb ? rdMux : 32'h00000000;
		end
	end

	// free running prescaler gives internal clocks one to five
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r)
			presc_r <= '0;
		else
			presc_r <= presc_r + 1'b1;
	end

	// global registers
	assign syncTrg = wrStb && (wb_adr_i == `TTC_OFF_BCTRL) && wb_sel_i[0]
		&& wb_dat_i[`TTC_BCTRL_SYNC];

	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r)
			blockMode_r <= `TTC_RST_BMODE;
		else if (wrStb && (wb_adr_i == `TTC_OFF_BMODE) && wb_sel_i[0])
			blockMode_r <= wb_dat_i[5:0];
	end

	// read mux, unmapped words read zero
	always_comb begin
		rdMux = 32'h00000000;
		if (wb_adr_i == `TTC_OFF_BMODE)
			rdMux = {26'h0, blockMode_r};
		for (int c = 0; c < NCH; c++) begin
			if (chHit(wb_adr_i, c, `TTC_OFF_MODE))
				rdMux = {16'h0, mode_r[c]};
			if (chHit(wb_adr_i, c, `TTC_OFF_COUNT))
				rdMux = {16'h0, cnt_r[c]};
			if (chHit(wb_adr_i, c, `TTC_OFF_CAPA))
				rdMux = {16'h0, capA_r[c]};
			if (chHit(wb_adr_i, c, `TTC_OFF_CAPB))
				rdMux = {16'h0, capB_r[c]};
			if (chHit(wb_adr_i, c, `TTC_OFF_CMPC))
				rdMux = {16'h0, cmpC_r[c]};
			if (chHit(wb_adr_i, c, `TTC_OFF_IMASK))
				rdMux = {24'h0, mask_r[c]};
			if (chHit(wb_adr_i, c, `TTC_OFF_STATUS)) begin
				rdMux = {24'h0, flags_r[c]};
				rdMux[`TTC_ST_CLOCK_ENABLED_STATUS] = clkEn_r[c];
				// mirror shows driven level in waveform mode, pin level otherwise
				rdMux[`TTC_ST_MIRA] = mode_r[c][`TTC_MODE_WAVE] ? lineAOut_r[c] : lineAIn[c];
				rdMux[`TTC_ST_MIRB] = mode_r[c][`TTC_MODE_WAVE] ? lineBOut_r[c] : lineBIn[c];
			end
		end
	end

	genvar n;
	generate
		for (n = 0; n < NCH; n++) begin : gCh
			logic [2:0] clkSel;
			logic [1:0] gateSel;
			ttc_edge_e trgSel;
			logic wave;
			logic [2:0] extClk;
			logic selLvl;
			logic gateLvl;
			logic cntLvl;
			logic cntLvlPrev_r;
			logic tick;
			logic step;
			logic stopped_r;
			logic armB_r;
			logic lineAPrev_r;
			logic lineBPrev_r;
			logic trgEdge;
			logic ldA;
			logic ldB;
			logic restart;
			logic atC;
			logic cpA;
			logic cpB;
			logic cpC;
			logic rdClr;
			logic ctrlWr;
			ttc_flags_t setv;

			assign clkSel = mode_r[n][`TTC_MODE_CLKSEL_LSB +: 3];
			assign gateSel = mode_r[n][`TTC_MODE_GATE_LSB +: 2];
			assign trgSel = ttc_edge_e'(mode_r[n][`TTC_MODE_TRGEDGE_LSB +: 2]);
			assign wave = mode_r[n][`TTC_MODE_WAVE];

			// each external clock: own pin, off, or line A of another channel
			for (genvar k = 0; k < 3; k++) begin : gExt
				always_comb begin
					unique case (blockMode_r[2*k +: 2])
						2'h0: extClk[k] = extClkPin[k];
						2'h1: extClk[k] = 1'b0;
						2'h2: extClk[k] = lineAOut_r[(k + 1) % NCH];
						default: extClk[k] = lineAOut_r[(k + 2) % NCH];
					endcase
				end
			end

			always_comb begin
				unique case (clkSel)
					3'h0: selLvl = presc_r[`TTC_TAP1];
					3'h1: selLvl = presc_r[`TTC_TAP2];
					3'h2: selLvl = presc_r[`TTC_TAP3];
					3'h3: selLvl = presc_r[`TTC_TAP4];
					3'h4: selLvl = presc_r[`TTC_TAP5];
					3'h5: selLvl = extClk[0];
					3'h6: selLvl = extClk[1];
					default: selLvl = extClk[2];
				endcase
			end

			always_comb begin
				unique case (gateSel)
					2'h0: gateLvl = selLvl;
					2'h1: gateLvl = selLvl & extClk[0];
					2'h2: gateLvl = selLvl & extClk[1];
					default: gateLvl = selLvl & extClk[2];
				endcase
			end

			// inverting the level turns a falling edge into the counted rising edge
			assign cntLvl = gateLvl ^ mode_r[n][`TTC_MODE_CLKINV];
			assign tick = cntLvl && !cntLvlPrev_r;
			assign step = tick && clkEn_r[n] && !stopped_r;

			// external trigger on line B, capture mode only
			always_comb begin
				unique case (trgSel)
					TTC_EDGE_NONE: trgEdge = 1'b0;
					TTC_EDGE_RISE: trgEdge = lineBIn[n] && !lineBPrev_r;
					TTC_EDGE_FALL: trgEdge = !lineBIn[n] && lineBPrev_r;
					TTC_EDGE_BOTH: trgEdge = lineBIn[n] != lineBPrev_r;
				endcase
				trgEdge = trgEdge && !wave;
			end

			// capture A on line A rise, B on the following fall
			assign ldA = !wave && lineAIn[n] && !lineAPrev_r;
			assign ldB = !wave && !lineAIn[n] && lineAPrev_r && armB_r;

			assign atC = cnt_r[n] == cmpC_r[n];
			assign cpA = wave && step && (cnt_r[n] == capA_r[n]);
			assign cpB = wave && step && (cnt_r[n] == capB_r[n]);
			assign cpC = step && atC;
			assign ctrlWr = wrStb && chHit(wb_adr_i, n, `TTC_OFF_CTRL) && wb_sel_i[0];
			assign restart = syncTrg || trgEdge || (ctrlWr && wb_dat_i[`TTC_CTRL_SWTRG])
				|| (wave && cpC);
			assign rdClr = rdStb && chHit(wb_adr_i, n, `TTC_OFF_STATUS);

			always_comb begin
				setv = '0;
				setv[`TTC_ST_OVF] = step && (&cnt_r[n]) && !restart;
				setv[`TTC_ST_LOVR] = (ldA && flags_r[n][`TTC_ST_LDA]) || (ldB && flags_r[n][`TTC_ST_LDB]);
				setv[`TTC_ST_CPA] = cpA;
				setv[`TTC_ST_CPB] = cpB;
				setv[`TTC_ST_CPC] = cpC;
				setv[`TTC_ST_LDA] = ldA;
				setv[`TTC_ST_LDB] = ldB;
				setv[`TTC_ST_ETRG] = trgEdge;
			end

			always_ff @(posedge clk or negedge rstSync_r) begin
				if (!rstSync_r) begin
					cntLvlPrev_r <= 1'b0;
					lineAPrev_r <= 1'b0;
					lineBPrev_r <= 1'b0;
				end else begin
					cntLvlPrev_r <= cntLvl;
					lineAPrev_r <= lineAIn[n];
					lineBPrev_r <= lineBIn[n];
				end
			end

			// counter wraps naturally at full scale
			always_ff @(posedge clk or negedge rstSync_r) begin
				if (!rstSync_r)
					cnt_r[n] <= '0;
				else if (restart)
					cnt_r[n] <= '0;
				else if (step)
					cnt_r[n] <= cnt_r[n] + 1'b1;
			end

			// clock enable and stop state
			always_ff @(posedge clk or negedge rstSync_r) begin
				if (!rstSync_r) begin
					clkEn_r[n] <= 1'b0;
					stopped_r <= 1'b0;
				end else begin
					if (ctrlWr && wb_dat_i[`TTC_CTRL_CLKDIS])
						clkEn_r[n] <= 1'b0;
					else if (ldB && mode_r[n][`TTC_MODE_DISB])
						clkEn_r[n] <= 1'b0;
					else if (ctrlWr && wb_dat_i[`TTC_CTRL_CLKEN])
						clkEn_r[n] <= 1'b1;
					// a stopped counter resumes only on a trigger
					if (ldB && mode_r[n][`TTC_MODE_STOPB])
						stopped_r <= 1'b1;
					else if (restart)
						stopped_r <= 1'b0;
				end
			end

			// capture registers, writable in waveform mode as compare values
			always_ff @(posedge clk or negedge rstSync_r) begin
				if (!rstSync_r) begin
					capA_r[n] <= `TTC_RST_CMP;
					capB_r[n] <= `TTC_RST_CMP;
					armB_r <= 1'b0;
				end else begin
					if (ldA)
						capA_r[n] <= cnt_r[n];
					else if (wave && wrStb && chHit(wb_adr_i, n, `TTC_OFF_CAPA))
						capA_r[n] <= CW'(selData(wb_dat_i, wb_sel_i));
					if (ldB)
						capB_r[n] <= cnt_r[n];
					else if (wave && wrStb && chHit(wb_adr_i, n, `TTC_OFF_CAPB))
						capB_r[n] <= CW'(selData(wb_dat_i, wb_sel_i));
					if (ldA)
						armB_r <= 1'b1;
					else if (ldB || restart)
						armB_r <= 1'b0;
				end
			end

			// mode and compare C
			always_ff @(posedge clk or negedge rstSync_r) begin
				if (!rstSync_r) begin
					mode_r[n] <= `TTC_RST_MODE;
					cmpC_r[n] <= `TTC_RST_CMP;
				end else begin
					if (wrStb && chHit(wb_adr_i, n, `TTC_OFF_MODE))
						mode_r[n] <= 16'(selData(wb_dat_i, wb_sel_i));
					if (wrStb && chHit(wb_adr_i, n, `TTC_OFF_CMPC))
						cmpC_r[n] <= CW'(selData(wb_dat_i, wb_sel_i));
				end
			end

			// status flags: an event in the reading cycle survives the clear
			always_ff @(posedge clk or negedge rstSync_r) begin
				if (!rstSync_r)
					flags_r[n] <= `TTC_RST_FLAGS;
				else
					flags_r[n] <= (rdClr ? 8'h00 : flags_r[n]) | setv;
			end

			// interrupt mask via write-one strobes
			always_ff @(posedge clk or negedge rstSync_r) begin
				if (!rstSync_r)
					mask_r[n] <= 8'h00;
				else if (wrStb && wb_sel_i[0] && chHit(wb_adr_i, n, `TTC_OFF_IEN))
					mask_r[n] <= mask_r[n] | wb_dat_i[7:0];
				else if (wrStb && wb_sel_i[0] && chHit(wb_adr_i, n, `TTC_OFF_IDIS))
					mask_r[n] <= mask_r[n] & ~wb_dat_i[7:0];
			end

			// interrupt follows flags one cycle late so the output is a flop
			always_ff @(posedge clk or negedge rstSync_r) begin
				if (!rstSync_r)
					irq[n] <= 1'b0;
				else
					irq[n] <= |(flags_r[n] & mask_r[n]);
			end

			// waveform: set at compare A or B, cleared at compare C
			always_ff @(posedge clk or negedge rstSync_r) begin
				if (!rstSync_r) begin
					lineAOut_r[n] <= 1'b0;
					lineBOut_r[n] <= 1'b0;
					lineAOe[n] <= 1'b0;
					lineBOe[n] <= 1'b0;
				end else begin
					lineAOe[n] <= wave;
					lineBOe[n] <= wave;
					if (!wave || cpC)
						lineAOut_r[n] <= 1'b0;
					else if (cpA)
						lineAOut_r[n] <= 1'b1;
					if (!wave || cpC)
						lineBOut_r[n] <= 1'b0;
					else if (cpB)
						lineBOut_r[n] <= 1'b1;
				end
			end
		end
	endgenerate

	assign lineAOut = lineAOut_r;
	assign lineBOut = lineBOut_r;

endmodule : ttc_timer
`default_nettype wire

// [ttc_cfg.svh]
// constants for the three channel timer counter: offsets, fields, resets, clock taps
// Notes on behaviour
// - three independent channels, 16-bit counters each
// - three external, five internal clocks, two lines
// - each channel drives its own interrupt line
// - block control sync write zeroes all counters together
// - block mode routes external clocks for chaining
// - trigger edge: none, rising, falling, both
// - disable on B load clears clock enable
// - stop on B load halts counting
// - gating ANDs selected clock with external clock
// - clock invert counts on falling edge
// - select 0-4 internal, 5-7 external clocks
// - status flags at documented bit positions
// - status read clears event flags, pending interrupt
// - trigger edge sets external trigger flag in capture mode
// - load flags set only in capture mode
// - counter equal compare C sets flag
// - clock enabled status mirrors clock enable
// - line mirrors: pin level or driven level
// - enable strobe write one sets mask
// - disable strobe write one clears mask
`ifndef TTC_CFG_SVH
`define TTC_CFG_SVH

// per channel register offsets inside a 0x40 window
`define TTC_OFF_CTRL 6'h00
`define TTC_OFF_MODE 6'h04
`define TTC_OFF_COUNT 6'h10
`define TTC_OFF_CAPA 6'h14
`define TTC_OFF_CAPB 6'h18
`define TTC_OFF_CMPC 6'h1C
`define TTC_OFF_STATUS 6'h20
`define TTC_OFF_IEN 6'h24
`define TTC_OFF_IDIS 6'h28
`define TTC_OFF_IMASK 6'h2C
// global registers
`define TTC_OFF_BCTRL 8'hC0
`define TTC_OFF_BMODE 8'hC4
`define TTC_GLOBAL_WIN 2'h3

// channel and block control bits
`define TTC_CTRL_CLKEN 0
`define TTC_CTRL_CLKDIS 1
`define TTC_CTRL_SWTRG 2
`define TTC_BCTRL_SYNC 0

// mode register fields
`define TTC_MODE_CLKSEL_LSB 0
`define TTC_MODE_CLKINV 3
`define TTC_MODE_GATE_LSB 4
`define TTC_MODE_STOPB 6
`define TTC_MODE_DISB 7
`define TTC_MODE_TRGEDGE_LSB 8
`define TTC_MODE_WAVE 15

// status bits
`define TTC_ST_OVF 0
`define TTC_ST_LOVR 1
`define TTC_ST_CPA 2
`define TTC_ST_CPB 3
`define TTC_ST_CPC 4
`define TTC_ST_LDA 5
`define TTC_ST_LDB 6
`define TTC_ST_ETRG 7
`define TTC_ST_CLOCK_ENABLED_STATUS 16
`define TTC_ST_MIRA 17
`define TTC_ST_MIRB 18

// reset values
`define TTC_RST_MODE 16'h0000
`define TTC_RST_CMP 16'h0000
`define TTC_RST_FLAGS 8'h00
`define TTC_RST_BMODE 6'h00

// prescaler taps giving the five internal clocks
`define TTC_PRESC_W 10
`define TTC_TAP1 0
`define TTC_TAP2 2
`define TTC_TAP3 4
`define TTC_TAP4 6
`define TTC_TAP5 9

`endif

// [ttc_pkg.sv]
// types shared by the three channel timer counter
package ttc_pkg;
	typedef logic [15:0] ttc_count_t;
	typedef logic [7:0] ttc_flags_t;
	typedef enum logic [1:0] {
		TTC_EDGE_NONE = 2'h0,
		TTC_EDGE_RISE = 2'h1,
		TTC_EDGE_FALL = 2'h2,
		TTC_EDGE_BOTH = 2'h3
	} ttc_edge_e;
endpackage : ttc_pkg

// [ttc_timer_sva.sv]
// assertions on the timer bus and line ports
`timescale 1ns/1ps
`default_nettype none
module ttc_timer_sva (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// line A of each channel
	input wire logic [2:0] lineAIn,
	input wire logic [2:0] lineAOe
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	logic rdReq, rdStat, rdMask, rdHole, lastA_r;
	logic [2:0] quiet_r;
	assign rdReq = wb_cyc_i && wb_stb_i && !wb_we_i;
	assign rdStat = rdReq && wb_adr_i[5:0] == 6'h20 && wb_adr_i[7:6] != 2'h3;
	assign rdMask = rdReq && wb_adr_i[5:0] == 6'h2C && wb_adr_i[7:6] != 2'h3;
	assign rdHole = rdReq && (wb_adr_i[7:6] == 2'h3 ? wb_adr_i[5:3] != 3'h0
		: (wb_adr_i[5:3] == 3'h1 || wb_adr_i[5:4] == 2'h3));
	// the mirror is judged only once the pin has been still for a while, so edge timing cannot confuse it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lastA_r <= 1'b0;
			quiet_r <= 3'h0;
		end else begin
			lastA_r <= lineAIn[0];
			quiet_r <= (lineAIn[0] != lastA_r) ? 3'h0 : ((quiet_r == 3'h7) ? 3'h7 : quiet_r + 3'h1);
		end
	end
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held past one cycle");
	ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing one cycle after request");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	data_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	upper_zero_a: assert property (wb_ack_o && $past(rdReq && wb_adr_i[5:0] != 6'h20) |-> wb_dat_o[31:16] == 16'h0)
		else $error("upper half of a register not zero");
	status_gap_a: assert property (wb_ack_o && $past(rdStat) |-> wb_dat_o[31:19] == 13'h0 && wb_dat_o[15:8] == 8'h0)
		else $error("status bit outside its layout");
	mask_width_a: assert property (wb_ack_o && $past(rdMask) |-> wb_dat_o[31:8] == 24'h0)
		else $error("mask bit outside event bits");
	hole_zero_a: assert property (wb_ack_o && $past(rdHole) |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	mirror_pin_a: assert property (wb_ack_o && $past(rdStat && wb_adr_i[7:6] == 2'h0 && !lineAOe[0] && quiet_r == 3'h7)
		|-> wb_dat_o[17] == $past(lineAIn[0]))
		else $error("line A mirror differs from pin");
endmodule : ttc_timer_sva

bind ttc_timer ttc_timer_sva u_sva (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .lineAIn(lineAIn),
	.lineAOe(lineAOe));
`default_nettype wire

// [ttc_line_model.sv]
// far side of the timer: external clock pins and both lines of each channel
`timescale 1ns/1ps
`default_nettype none
module ttc_line_model (
	// clock
	input wire logic clk,
	// levels the bench asks for
	input wire logic [2:0] extReq,
	input wire logic [2:0] aReq,
	input wire logic [2:0] bReq,
	// what the timer drives
	input wire logic [2:0] lineAOut,
	input wire logic [2:0] lineAOe,
	input wire logic [2:0] lineBOut,
	input wire logic [2:0] lineBOe,
	// pin levels seen by the timer
	output logic [2:0] extClkPin,
	output logic [2:0] lineAIn,
	output logic [2:0] lineBIn
);
	logic [2:0] extLvl_r, aLvl_r, bLvl_r;
	// pins move just after an edge, as board logic on the same clock would
	always_ff @(posedge clk) begin
		extLvl_r <= extReq;
		aLvl_r <= aReq;
		bLvl_r <= bReq;
	end
	assign extClkPin = extLvl_r;
	// a line the timer drives shows its level, otherwise the far side's
	assign lineAIn = (lineAOe & lineAOut) | (~lineAOe & aLvl_r);
	assign lineBIn = (lineBOe & lineBOut) | (~lineBOe & bLvl_r);
endmodule : ttc_line_model
`default_nettype wire

// [ttc_timer_test.sv]
// self-checking bench for the three channel timer counter
`timescale 1ns/1ps
`default_nettype none
`include "ttc_cfg.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin errors++; $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module ttc_timer_test
	import ttc_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n, wbCyc, wbStb, wbWe, wbAck;
	logic [1:0] ch;
	logic [7:0] wbAdr;
	logic [3:0] wbSel;
	logic [31:0] wbDat, wbDatO, rdVal, cnt0;
	logic [2:0] extReq, aReq, bReq, extClkPin, lineAIn, lineBIn, lineAOut, lineAOe, lineBOut, lineBOe, irq;
	int errors = 0;
	int checks = 0;

	always #25 clk = ~clk;

	ttc_timer u_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
		.wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .extClkPin(extClkPin),
		.lineAIn(lineAIn), .lineAOut(lineAOut), .lineAOe(lineAOe), .lineBIn(lineBIn), .lineBOut(lineBOut),
		.lineBOe(lineBOe), .irq(irq));
	ttc_line_model u_far (.clk(clk), .extReq(extReq), .aReq(aReq), .bReq(bReq), .lineAOut(lineAOut),
		.lineAOe(lineAOe), .lineBOut(lineBOut), .lineBOe(lineBOe), .extClkPin(extClkPin), .lineAIn(lineAIn),
		.lineBIn(lineBIn));

	task automatic print_verdict();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : print_verdict

	function automatic logic [7:0] regAdr(input logic [1:0] c, input logic [5:0] off);
		return {c, off};
	endfunction : regAdr

	// ack, read data and the release all belong to the one rising edge that samples ack high
	task automatic wbXfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= w;
		wbAdr <= a;
		wbDat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (wbAck !== 1'b1 && n < 16);
		q = wbDatO;
		if (wbAck !== 1'b1) begin
			errors++;
			$display("unexpected at %0t: no bus answer", $time);
			print_verdict();
		end
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask : wbXfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wbXfer(a, 1'b1, d, rdVal);
	endtask : wr

	task automatic chkRd(input logic [7:0] a, input logic [31:0] exp);
		wbXfer(a, 1'b0, 32'h0, rdVal);
		`CHK(rdVal, exp)
	endtask : chkRd

	// pins settle for eight clocks before anything is read
	task automatic pins(input logic [2:0] e, input logic [2:0] a, input logic [2:0] b);
		@(posedge clk);
		extReq <= e;
		aReq <= a;
		bReq <= b;
		repeat (8) @(posedge clk);
	endtask : pins

	task automatic done(input string name);
		$display("test %s finished, %0d checks", name, checks);
	endtask : done

	initial begin
		rst_n = 1'b0;
		wbCyc = 1'b0;
		wbStb = 1'b0;
		wbWe = 1'b0;
		wbAdr = 8'h00;
		wbSel = 4'hF;
		wbDat = 32'h0;
		extReq = 3'h0;
		aReq = 3'h0;
		bReq = 3'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		for (ch = 2'h0; ch < 2'h3; ch++) begin
			chkRd(regAdr(ch, `TTC_OFF_STATUS), 32'h0);
			chkRd(regAdr(ch, `TTC_OFF_IMASK), 32'h0);
			wr(regAdr(ch, `TTC_OFF_IEN), 32'hA5);
			chkRd(regAdr(ch, `TTC_OFF_IMASK), 32'hA5);
			wr(regAdr(ch, `TTC_OFF_IDIS), 32'h05);
			chkRd(regAdr(ch, `TTC_OFF_IMASK), 32'hA0);
			wr(regAdr(ch, `TTC_OFF_IDIS), 32'hFF);
			chkRd(regAdr(ch, `TTC_OFF_IMASK), 32'h0);
		end
		wr(8'hD0, 32'hFFFFFFFF);
		chkRd(8'hD0, 32'h0);
		chkRd(regAdr(2'h0, 6'h08), 32'h0);
		done("registers");
		wr(regAdr(2'h0, `TTC_OFF_CMPC), 32'h1234);
		// mode before control: the sw trigger clears any count the mode change caused
		for (int inv = 0; inv < 2; inv++) begin
			wr(regAdr(2'h0, `TTC_OFF_MODE), 32'h5 | (inv << 3));
			wr(regAdr(2'h0, `TTC_OFF_CTRL), 32'h5);
			pins(3'h1, 3'h0, 3'h0);
			pins(3'h0, 3'h0, 3'h0);
			pins(3'h1, 3'h0, 3'h0);
			chkRd(regAdr(2'h0, `TTC_OFF_COUNT), (inv != 0) ? 32'h1 : 32'h2);
			pins(3'h0, 3'h0, 3'h0);
		end
		wr(regAdr(2'h0, `TTC_OFF_MODE), 32'h5);
		for (int b = 1; b >= 0; b--) begin
			wr(`TTC_OFF_BCTRL + 8'h04, b);
			wr(regAdr(2'h0, `TTC_OFF_CTRL), 32'h5);
			pins(3'h1, 3'h0, 3'h0);
			pins(3'h0, 3'h0, 3'h0);
			chkRd(regAdr(2'h0, `TTC_OFF_COUNT), (b != 0) ? 32'h0 : 32'h1);
		end
		wr(`TTC_OFF_BCTRL, 32'h1);
		chkRd(regAdr(2'h0, `TTC_OFF_COUNT), 32'h0);
		done("clock sources");
		wr(regAdr(2'h0, `TTC_OFF_MODE), 32'h16);
		for (int g = 0; g < 2; g++) begin
			pins({2'h0, g[0]}, 3'h0, 3'h0);
			wr(regAdr(2'h0, `TTC_OFF_CTRL), 32'h5);
			repeat (2) begin
				pins({2'h1, g[0]}, 3'h0, 3'h0);
				pins({2'h0, g[0]}, 3'h0, 3'h0);
			end
			chkRd(regAdr(2'h0, `TTC_OFF_COUNT), (g != 0) ? 32'h2 : 32'h0);
		end
		pins(3'h0, 3'h0, 3'h0);
		wbXfer(regAdr(2'h0, `TTC_OFF_STATUS), 1'b0, 32'h0, rdVal);
		chkRd(regAdr(2'h0, `TTC_OFF_STATUS), 32'h10000);
		wr(regAdr(2'h0, `TTC_OFF_CTRL), 32'h2);
		chkRd(regAdr(2'h0, `TTC_OFF_STATUS), 32'h0);
		done("gating");
		for (int s = 0; s < 2; s++) begin
			wr(regAdr(2'h0, `TTC_OFF_MODE), (s != 0) ? 32'h40 : 32'h80);
			wr(regAdr(2'h0, `TTC_OFF_CTRL), 32'h5);
			wbXfer(regAdr(2'h0, `TTC_OFF_STATUS), 1'b0, 32'h0, rdVal);
			pins(3'h0, 3'h1, 3'h0);
			chkRd(regAdr(2'h0, `TTC_OFF_STATUS), 32'h30020);
			pins(3'h0, 3'h0, 3'h0);
			chkRd(regAdr(2'h0, `TTC_OFF_STATUS), (s != 0) ? 32'h10040 : 32'h40);
			wbXfer(regAdr(2'h0, `TTC_OFF_COUNT), 1'b0, 32'h0, cnt0);
			repeat (20) @(posedge clk);
			chkRd(regAdr(2'h0, `TTC_OFF_COUNT), cnt0);
		end
		done("capture");
		for (int e = 0; e < 4; e++) begin
			wr(regAdr(2'h1, `TTC_OFF_MODE), e << 8);
			wbXfer(regAdr(2'h1, `TTC_OFF_STATUS), 1'b0, 32'h0, rdVal);
			pins(3'h0, 3'h0, 3'h2);
			chkRd(regAdr(2'h1, `TTC_OFF_STATUS), (e == TTC_EDGE_RISE || e == TTC_EDGE_BOTH) ? 32'h40080 : 32'h40000);
			pins(3'h0, 3'h0, 3'h0);
			chkRd(regAdr(2'h1, `TTC_OFF_STATUS), (e == TTC_EDGE_FALL || e == TTC_EDGE_BOTH) ? 32'h80 : 32'h0);
		end
		done("trigger");
		wr(regAdr(2'h2, `TTC_OFF_CMPC), 32'h2);
		wr(regAdr(2'h2, `TTC_OFF_IEN), 32'h10);
		wr(regAdr(2'h2, `TTC_OFF_MODE), 32'h7);
		wr(regAdr(2'h2, `TTC_OFF_CTRL), 32'h5);
		wbXfer(regAdr(2'h2, `TTC_OFF_STATUS), 1'b0, 32'h0, rdVal);
		// compare C is seen on the step taken while the count equals it, so a third edge
		repeat (3) begin
			pins(3'h4, 3'h0, 3'h0);
			pins(3'h0, 3'h0, 3'h0);
		end
		@(negedge clk);
		`CHK(irq, 3'h4)
		chkRd(regAdr(2'h2, `TTC_OFF_STATUS), 32'h10010);
		repeat (3) @(negedge clk);
		`CHK(irq, 3'h0)
		done("compare and interrupt");
		wr(regAdr(2'h2, `TTC_OFF_CMPC), 32'h4);
		wr(regAdr(2'h2, `TTC_OFF_MODE), 32'h8007);
		wr(regAdr(2'h2, `TTC_OFF_CAPA), 32'h1);
		wr(regAdr(2'h2, `TTC_OFF_CAPB), 32'h2);
		wr(regAdr(2'h2, `TTC_OFF_CTRL), 32'h5);
		wbXfer(regAdr(2'h2, `TTC_OFF_STATUS), 1'b0, 32'h0, rdVal);
		// count 0 to 1, then the step taken at 1 meets compare A
		repeat (2) begin
			pins(3'h4, 3'h0, 3'h0);
			pins(3'h0, 3'h0, 3'h0);
		end
		@(negedge clk);
		`CHK({lineAOe, lineBOe}, 6'h24)
		`CHK({lineAOut, lineBOut}, 6'h20)
		pins(3'h4, 3'h0, 3'h0);
		chkRd(regAdr(2'h2, `TTC_OFF_STATUS), 32'h7000C);
		repeat (2) begin
			pins(3'h0, 3'h0, 3'h0);
			pins(3'h4, 3'h0, 3'h0);
		end
		@(negedge clk);
		`CHK({lineAOut, lineBOut}, 6'h00)
		chkRd(regAdr(2'h2, `TTC_OFF_STATUS), 32'h10010);
		done("waveform");
		print_verdict();
	end
endmodule : ttc_timer_test
`default_nettype wire
